// ==== aic_pkg.sv ====
// Constants and the state type of the analog input conditioning block.
// Assumes one 25 MHz control clock and an APB register port with word-aligned registers.
`default_nettype none
package aic_pkg;
    // ************************************************************
    // Register indices: byte address is four times the index
    // ************************************************************
    localparam logic [13:0] IDX_FSEL1 = 14'h0300;
    localparam logic [13:0] IDX_FSEL2 = 14'h0301;
    localparam logic [13:0] IDX_BIAS1 = 14'h0302;
    localparam logic [13:0] IDX_BIAS2 = 14'h0303;
    localparam logic [13:0] IDX_BMODE1 = 14'h0304;
    localparam logic [13:0] IDX_BMODE2 = 14'h0308;
    localparam logic [13:0] IDX_REV_EN = 14'h030A;
    localparam logic [13:0] IDX_GAIN1 = 14'h030B;
    localparam logic [13:0] IDX_GAIN2 = 14'h030C;
    localparam logic [13:0] IDX_FTIME1 = 14'h030F;
    localparam logic [13:0] IDX_FTIME2 = 14'h0310;
    localparam logic [13:0] IDX_SUM_EN = 14'h0312;
    localparam logic [13:0] IDX_ALT_SEL = 14'h0332;
    localparam logic [13:0] IDX_SRC_CTRL = 14'h0340;
    localparam logic [13:0] IDX_MAX_FREQ = 14'h0341;
    localparam logic [13:0] IDX_MAX_TORQUE = 14'h0342;
    localparam logic [13:0] IDX_RATED_TORQUE = 14'h0343;
    localparam logic [13:0] IDX_VAL_SEL = 14'h0344;
    localparam logic [13:0] IDX_VAL_READ = 14'h0345;
    localparam logic [13:0] IDX_FILT1 = 14'h0346;
    localparam logic [13:0] IDX_FILT2 = 14'h0347;
    localparam logic [13:0] IDX_PID_REF = 14'h0348;
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] RST_FSEL1 = 16'h0001;
    localparam logic [15:0] RST_FSEL2 = 16'h0000;
    localparam logic [15:0] RST_GAIN = 16'h03E8;
    localparam logic [15:0] RST_FTIME = 16'h0001;
    localparam logic [15:0] RST_MAX_FREQ = 16'h1770;
    localparam logic [15:0] RST_MAX_TORQUE = 16'h03E8;
    localparam logic [15:0] RST_RATED_TORQUE = 16'h03E8;
    localparam logic [15:0] RST_SRC_CTRL = 16'h0001;
    // ************************************************************
    // Function codes and bias modes
    // ************************************************************
    localparam int NFUNC = 14;
    localparam logic [15:0] FN_NONE = 16'h0000;
    localparam logic [15:0] FN_FREQ = 16'h0001;
    localparam logic [15:0] FN_TORQUE = 16'h0002;
    localparam logic [15:0] FN_TQ_COMP = 16'h0003;
    localparam logic [15:0] FN_PID_TARGET = 16'h0004;
    localparam logic [15:0] FN_AUX_FREQ = 16'h000C;
    localparam logic [15:0] BM_NONE = 16'h0000;
    localparam logic [15:0] BM_CLAMP = 16'h0001;
    localparam logic [15:0] BM_ABS = 16'h0003;
    localparam logic [15:0] BM_CENTRE = 16'h0004;
    // ************************************************************
    // Limits, scaling and filter timing
    // ************************************************************
    localparam logic [15:0] BIAS_LIM = 16'h03E8;
    localparam logic [15:0] GAIN_LIM = 16'h1388;
    localparam logic [15:0] FTIME_MAX = 16'h07D0;
    localparam int PCT_FULL = 1000;
    localparam int SRC_ANALOG_BIT = 0;
    localparam int FILT_SHIFT = 4;
    localparam int TICK_NS = 625000;
    localparam int CLK_NS = 40;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;

    typedef struct packed {
        logic [1:0][15:0] fsel;
        logic [1:0][15:0] bias;
        logic [1:0][15:0] bmode;
        logic [1:0][15:0] gain;
        logic [1:0][15:0] ftime;
        logic [1:0][15:0] fcnt;
        logic [1:0][23:0] acc;
        logic [15:0] rev_en;
        logic [15:0] sum_en;
        logic [15:0] alt_sel;
        logic [15:0] src_ctrl;
        logic [15:0] max_freq;
        logic [15:0] max_torque;
        logic [15:0] rated_torque;
        logic [15:0] val_sel;
        logic [15:0] tick_cnt;
        logic [31:0] prdata;
        logic pslverr;
        logic [13:0][31:0] fval;
        logic [13:0] fvalid;
        logic [31:0] pid_ref;
        logic reverse_run;
        logic dir_locked;
    } aic_state_t;
endpackage : aic_pkg
`default_nettype wire

// ==== aic_top.sv ====
// Analog input conditioning: filter, bias, gain and function routing of two analog commands.
// Assumes the samples come from converter logic on pclk, 0000h..FFFFh spanning the full input range.
`default_nettype none

// Overview of operation
// - Decode fourteen function codes per input
// - Same code on both: first input wins
// - Frequency plus PID target: first is reference
// - Frequency span maps to maximum operating frequency
// - Torque span maps to maximum output torque
// - Compensation span maps to rated torque
// - Signed bias, plus minus 100.0 percent
// - Alternative scaling nonzero disables bias, gain, reverse
// - Bias modes none, clamp, absolute centre, centre
// - Reverse permission chooses direction source
// - Negative only with permission, centre, negative gain
// - Scaling applies with analog frequency source
// - Filter time 0.00 to 20.00 seconds
// - Addition enable sums both inputs
// - Negative sum reverses only when permitted
module aic_top #(
    parameter int TICK_CYCLES = aic_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog samples
    input wire logic [15:0] analog_input_one,
    input wire logic [15:0] analog_input_two,
    // Conditioned commands
    output logic [13:0][31:0] func_value,
    output logic [13:0] func_valid,
    output logic [31:0] pid_reference,
    output logic reverse_run,
    output logic direction_locked
);
    aic_pkg::aic_state_t st;
    aic_pkg::aic_state_t nx;
    logic [1:0][15:0] x_in;
    logic [1:0][9:0] x_pm;
    logic [1:0][23:0] ch_raw;
    logic [1:0][23:0] ch_val;
    logic [1:0] ch_neg_ok;
    logic active;
    logic signed [23:0] sum_raw;
    logic [23:0] sum_val;
    logic tick;
    logic hit0;
    logic hit1;
    logic signed [23:0] pm;
    logic [15:0] fs;
    logic signed [24:0] filt_diff;
    logic [31:0] rd_data;
    logic rd_hit;
    logic [13:0] idx;
    logic req_ok;

    function automatic logic [15:0] aic_clamp(input logic [15:0] v, input logic [15:0] lim);
        logic signed [15:0] s;
        s = $signed(v);
        if (s > $signed(lim))
        begin
            return lim;
        end
        if (s < -$signed(lim))
        begin
            return 16'(-$signed(lim));
        end
        return v;
    endfunction : aic_clamp

    function automatic logic [31:0] aic_scale(input logic signed [23:0] p, input logic [15:0] f);
        logic signed [40:0] prod;
        prod = 41'(p) * 41'($signed({1'b0, f}));
        prod = prod / 41'(aic_pkg::PCT_FULL);
        return prod[31:0];
    endfunction : aic_scale

    // ************************************************************
    // Per-input bias and gain
    // ************************************************************
    assign x_in[0] = analog_input_one;
    assign x_in[1] = analog_input_two;
    assign active = (st.alt_sel == 16'h0000) && st.src_ctrl[aic_pkg::SRC_ANALOG_BIT];

    generate
        for (genvar c = 0; c < 2; c++)
        begin : g_ch
            logic [25:0] prod_x;
            logic signed [17:0] xs;
            logic signed [17:0] b;
            logic signed [17:0] babs;
            logic signed [17:0] v;
            logic signed [15:0] g;
            logic [15:0] m;
            logic signed [33:0] scaled;
            assign prod_x = 26'(st.acc[c][23:8]) * 26'(aic_pkg::PCT_FULL);
            assign x_pm[c] = prod_x[25:16];
            assign xs = $signed({8'h00, x_pm[c]});
            assign b = active ? 18'($signed(st.bias[c])) : 18'sh00000;
            assign babs = (b < 0) ? -b : b;
            assign m = active ? st.bmode[c] : aic_pkg::BM_NONE;
            assign g = active ? $signed(st.gain[c]) : $signed(aic_pkg::RST_GAIN);
            always_comb
            begin
                case (m)
                    aic_pkg::BM_CLAMP: v = (xs <= b) ? b : xs;
                    aic_pkg::BM_ABS: v = xs - babs;
                    aic_pkg::BM_CENTRE: v = xs - b;
                    default: v = xs + b;
                endcase
                // Unipolar modes never go below zero before the gain
                if ((m != aic_pkg::BM_ABS) && (m != aic_pkg::BM_CENTRE) && (v < 0))
                begin
                    v = 18'sh00000;
                end
                scaled = (34'(v) * 34'(g)) / 34'(aic_pkg::PCT_FULL);
            end
            assign ch_raw[c] = scaled[23:0];
            assign ch_neg_ok[c] = st.rev_en[0] && active && (m == aic_pkg::BM_CENTRE) && (g < 0);
            assign ch_val[c] = ($signed(ch_raw[c]) < 0 && !ch_neg_ok[c]) ? 24'h000000 : ch_raw[c];
        end
    endgenerate

    assign sum_raw = $signed(ch_raw[0]) + $signed(ch_raw[1]);
    assign sum_val = (sum_raw < 0 && !(ch_neg_ok[0] || ch_neg_ok[1])) ? 24'h000000 : sum_raw;
    assign tick = st.tick_cnt == 16'(TICK_CYCLES - 1);
    assign idx = paddr[15:2];

    // ************************************************************
    // Register read decode
    // ************************************************************
    always_comb
    begin
        rd_hit = 1'b1;
        rd_data = 32'h00000000;
        case (idx)
            aic_pkg::IDX_FSEL1: rd_data = {16'h0000, st.fsel[0]};
            aic_pkg::IDX_FSEL2: rd_data = {16'h0000, st.fsel[1]};
            aic_pkg::IDX_BIAS1: rd_data = {16'h0000, st.bias[0]};
            aic_pkg::IDX_BIAS2: rd_data = {16'h0000, st.bias[1]};
            aic_pkg::IDX_BMODE1: rd_data = {16'h0000, st.bmode[0]};
            aic_pkg::IDX_BMODE2: rd_data = {16'h0000, st.bmode[1]};
            aic_pkg::IDX_REV_EN: rd_data = {16'h0000, st.rev_en};
            aic_pkg::IDX_GAIN1: rd_data = {16'h0000, st.gain[0]};
            aic_pkg::IDX_GAIN2: rd_data = {16'h0000, st.gain[1]};
            aic_pkg::IDX_FTIME1: rd_data = {16'h0000, st.ftime[0]};
            aic_pkg::IDX_FTIME2: rd_data = {16'h0000, st.ftime[1]};
            aic_pkg::IDX_SUM_EN: rd_data = {16'h0000, st.sum_en};
            aic_pkg::IDX_ALT_SEL: rd_data = {16'h0000, st.alt_sel};
            aic_pkg::IDX_SRC_CTRL: rd_data = {16'h0000, st.src_ctrl};
            aic_pkg::IDX_MAX_FREQ: rd_data = {16'h0000, st.max_freq};
            aic_pkg::IDX_MAX_TORQUE: rd_data = {16'h0000, st.max_torque};
            aic_pkg::IDX_RATED_TORQUE: rd_data = {16'h0000, st.rated_torque};
            aic_pkg::IDX_VAL_SEL: rd_data = {16'h0000, st.val_sel};
            aic_pkg::IDX_VAL_READ: rd_data = (st.val_sel[3:0] < 4'(aic_pkg::NFUNC)) ? st.fval[st.val_sel[3:0]] : 32'h0;
            aic_pkg::IDX_FILT1: rd_data = {16'h0000, st.acc[0][23:8]};
            aic_pkg::IDX_FILT2: rd_data = {16'h0000, st.acc[1][23:8]};
            aic_pkg::IDX_PID_REF: rd_data = st.pid_ref;
            default: rd_hit = 1'b0;
        endcase
    end
    assign req_ok = rd_hit && (paddr[1:0] == 2'b00);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        nx = st;
        hit0 = 1'b0;
        hit1 = 1'b0;
        pm = 24'sh000000;
        fs = 16'h0000;
        filt_diff = 25'sh0000000;
        // Registered answer keeps the bus at zero wait states
        if (psel && !penable)
        begin
            nx.prdata = req_ok ? rd_data : 32'h00000000;
            nx.pslverr = !req_ok;
        end
        if (psel && penable && pwrite && req_ok)
        begin
            case (idx)
                aic_pkg::IDX_FSEL1: nx.fsel[0] = pwdata[15:0];
                aic_pkg::IDX_FSEL2: nx.fsel[1] = pwdata[15:0];
                aic_pkg::IDX_BIAS1: nx.bias[0] = aic_clamp(pwdata[15:0], aic_pkg::BIAS_LIM);
                aic_pkg::IDX_BIAS2: nx.bias[1] = aic_clamp(pwdata[15:0], aic_pkg::BIAS_LIM);
                aic_pkg::IDX_BMODE1: nx.bmode[0] = pwdata[15:0];
                aic_pkg::IDX_BMODE2: nx.bmode[1] = pwdata[15:0];
                aic_pkg::IDX_REV_EN: nx.rev_en = pwdata[15:0];
                aic_pkg::IDX_GAIN1: nx.gain[0] = aic_clamp(pwdata[15:0], aic_pkg::GAIN_LIM);
                aic_pkg::IDX_GAIN2: nx.gain[1] = aic_clamp(pwdata[15:0], aic_pkg::GAIN_LIM);
                aic_pkg::IDX_FTIME1: nx.ftime[0] = (pwdata[15:0] > aic_pkg::FTIME_MAX) ? aic_pkg::FTIME_MAX : pwdata[15:0];
                aic_pkg::IDX_FTIME2: nx.ftime[1] = (pwdata[15:0] > aic_pkg::FTIME_MAX) ? aic_pkg::FTIME_MAX : pwdata[15:0];
                aic_pkg::IDX_SUM_EN: nx.sum_en = pwdata[15:0];
                aic_pkg::IDX_ALT_SEL: nx.alt_sel = pwdata[15:0];
                aic_pkg::IDX_SRC_CTRL: nx.src_ctrl = pwdata[15:0];
                aic_pkg::IDX_MAX_FREQ: nx.max_freq = pwdata[15:0];
                aic_pkg::IDX_MAX_TORQUE: nx.max_torque = pwdata[15:0];
                aic_pkg::IDX_RATED_TORQUE: nx.rated_torque = pwdata[15:0];
                aic_pkg::IDX_VAL_SEL: nx.val_sel = pwdata[15:0];
                default: nx.val_sel = st.val_sel;
            endcase
        end
        // Fixed shift with a stretched update period gives tau = 16 x period = filter time
        nx.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;
        for (int c = 0; c < 2; c++)
        begin
            if (tick)
            begin
                if (st.fcnt[c] >= st.ftime[c])
                begin
                    nx.fcnt[c] = 16'h0000;
                    filt_diff = $signed({1'b0, x_in[c], 8'h00}) - $signed({1'b0, st.acc[c]});
                    nx.acc[c] = 24'($signed({1'b0, st.acc[c]}) + (filt_diff >>> aic_pkg::FILT_SHIFT));
                end
                else
                begin
                    nx.fcnt[c] = st.fcnt[c] + 16'h0001;
                end
            end
        end
        // Function routing: the first input wins a shared code unless summing
        nx.fval[0] = 32'h00000000;
        nx.fvalid[0] = 1'b0;
        for (int f = 1; f < aic_pkg::NFUNC; f++)
        begin
            hit0 = st.fsel[0] == 16'(f);
            hit1 = st.fsel[1] == 16'(f);
            if (st.sum_en[0] && hit0 && hit1)
            begin
                pm = sum_val;
            end
            else if (hit0)
            begin
                pm = ch_val[0];
            end
            else if (hit1)
            begin
                pm = ch_val[1];
            end
            else
            begin
                pm = 24'sh000000;
            end
            case (16'(f))
                aic_pkg::FN_FREQ: fs = st.max_freq;
                aic_pkg::FN_AUX_FREQ: fs = st.max_freq;
                aic_pkg::FN_TORQUE: fs = st.max_torque;
                aic_pkg::FN_TQ_COMP: fs = st.rated_torque;
                default: fs = 16'(aic_pkg::PCT_FULL);
            endcase
            nx.fval[f] = aic_scale(pm, fs);
            nx.fvalid[f] = hit0 || hit1;
        end
        if (st.fsel[0] == aic_pkg::FN_FREQ || st.fsel[0] == aic_pkg::FN_PID_TARGET)
        begin
            nx.pid_ref = 32'($signed(ch_val[0]));
        end
        else if (st.fsel[1] == aic_pkg::FN_FREQ || st.fsel[1] == aic_pkg::FN_PID_TARGET)
        begin
            nx.pid_ref = 32'($signed(ch_val[1]));
        end
        else
        begin
            nx.pid_ref = 32'h00000000;
        end
        nx.reverse_run = nx.fval[1][31];
        nx.dir_locked = st.rev_en[0] && active;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.fsel[0] <= aic_pkg::RST_FSEL1;
            st.fsel[1] <= aic_pkg::RST_FSEL2;
            st.gain[0] <= aic_pkg::RST_GAIN;
            st.gain[1] <= aic_pkg::RST_GAIN;
            st.ftime[0] <= aic_pkg::RST_FTIME;
            st.ftime[1] <= aic_pkg::RST_FTIME;
            st.max_freq <= aic_pkg::RST_MAX_FREQ;
            st.max_torque <= aic_pkg::RST_MAX_TORQUE;
            st.rated_torque <= aic_pkg::RST_RATED_TORQUE;
            st.src_ctrl <= aic_pkg::RST_SRC_CTRL;
        end
        else
        begin
            st <= nx;
        end
    end

    assign prdata = st.prdata;
    assign pslverr = st.pslverr;
    assign pready = 1'b1;
    assign func_value = st.fval;
    assign func_valid = st.fvalid;
    assign pid_reference = st.pid_ref;
    assign reverse_run = st.reverse_run;
    assign direction_locked = st.dir_locked;

    // ************************************************************
    // Assertions
    // ************************************************************
    // Outputs are registered, so checks on them look one cycle after the cause
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    shared_code_a: assert property ((st.fsel[0] == aic_pkg::FN_FREQ) && (st.fsel[1] == aic_pkg::FN_FREQ) && !st.sum_en[0]
        |=> st.fval[1] == aic_scale($past(ch_val[0]), $past(st.max_freq))) else $error("second input not ignored");
    pid_ref_a: assert property ((st.fsel[0] == aic_pkg::FN_FREQ) && (st.fsel[1] == aic_pkg::FN_PID_TARGET)
        || (st.fsel[0] == aic_pkg::FN_PID_TARGET) && (st.fsel[1] == aic_pkg::FN_FREQ)
        |=> st.pid_ref == 32'($signed($past(ch_val[0])))) else $error("pid reference not from first input");
    decode_a: assert property ((st.fsel[0] == aic_pkg::FN_TQ_COMP) |=> st.fvalid[3] && !st.fvalid[0])
        else $error("function code not decoded");
    bias_range_a: assert property ($signed(st.bias[0]) <= $signed(aic_pkg::BIAS_LIM)
        && $signed(st.bias[1]) >= -$signed(aic_pkg::BIAS_LIM)) else $error("bias out of range");
    gain_range_a: assert property ($signed(st.gain[1]) <= $signed(aic_pkg::GAIN_LIM)
        && $signed(st.gain[0]) >= -$signed(aic_pkg::GAIN_LIM)) else $error("gain out of range");
    alt_ignore_a: assert property ((st.alt_sel != 16'h0000) |-> (ch_raw[0] == 24'(x_pm[0])) && !ch_neg_ok[1])
        else $error("scaling active under alternative selector");
    no_reverse_a: assert property ((st.rev_en == 16'h0000) [*2] |-> !st.reverse_run && !st.dir_locked)
        else $error("reverse without permission");
    reverse_cause_a: assert property ($rose(st.reverse_run) |-> $past(ch_neg_ok[0] || ch_neg_ok[1]))
        else $error("reverse without centre mode and negative gain");
    sum_a: assert property ((st.fsel[0] == aic_pkg::FN_FREQ) && (st.fsel[1] == aic_pkg::FN_FREQ) && st.sum_en[0]
        |=> st.fval[1] == aic_scale($signed($past(sum_val)), $past(st.max_freq))) else $error("inputs not summed");
    filter_hold_a: assert property (!tick |=> $stable(st.acc)) else $error("filter moved between ticks");
    filter_time_a: assert property (st.ftime[0] <= aic_pkg::FTIME_MAX && st.ftime[1] <= aic_pkg::FTIME_MAX)
        else $error("filter time out of range");
    unmapped_a: assert property (psel && !penable && !req_ok |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    torque_scale_a: assert property ((st.fsel[0] == aic_pkg::FN_TORQUE) && !st.sum_en[0]
        |=> st.fval[2] == aic_scale($past(ch_val[0]), $past(st.max_torque))) else $error("torque not scaled");
    comp_scale_a: assert property ((st.fsel[0] == aic_pkg::FN_TQ_COMP) && !st.sum_en[0]
        |=> st.fval[3] == aic_scale($past(ch_val[0]), $past(st.rated_torque))) else $error("compensation not scaled");
    clamp_mode_a: assert property (active && (st.bmode[0] == aic_pkg::BM_CLAMP) |-> g_ch[0].v >= g_ch[0].b)
        else $error("clamp mode below bias");
    source_gate_a: assert property (!st.src_ctrl[aic_pkg::SRC_ANALOG_BIT] |-> ch_raw[0] == 24'(x_pm[0]))
        else $error("scaling active without analog source");
    sum_guard_a: assert property (st.sum_en[0] && !ch_neg_ok[0] && !ch_neg_ok[1]
        |-> !sum_val[23]) else $error("negative sum passed");
    single_code_a: assert property ((st.fsel[0] == aic_pkg::FN_AUX_FREQ) && (st.fsel[1] == aic_pkg::FN_NONE)
        |=> st.fvalid == 14'h1000) else $error("function valid not one-hot");

    sum_reverse_c: cover property (st.sum_en[0] && st.reverse_run);
    pid_conflict_c: cover property ((st.fsel[0] == aic_pkg::FN_PID_TARGET) && (st.fsel[1] == aic_pkg::FN_FREQ));
    filter_step_c: cover property (tick ##1 !$stable(st.acc));
    apb_write_c: cover property (psel && penable && pwrite && req_ok);
    reverse_c: cover property ($rose(st.reverse_run));
endmodule : aic_top
`default_nettype wire

// ==== analog_input_conditioning_bench.sv ====
// Bench of the analog input conditioning block: APB register traffic and the command outputs.
// Assumes aic_pkg and aic_top are compiled first; the bench drives every input itself.
`default_nettype none
module analog_input_conditioning_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Signals, notes and counters
    // ************************************************************
    typedef struct {logic [4:0] k; logic [32:0] v;} aic_note_t;
    typedef struct {logic [15:0] m, b, g, r; logic [31:0] e;} aic_row_t;
    // Full-scale sample settles a few LSB low, which still reads 99.9 percent
    localparam int XPM = 999;
    localparam int F = XPM * int'(aic_pkg::RST_MAX_FREQ) / 1000;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, look = 0;
    logic [15:0] paddr = '0, ain1 = '0, ain2 = '0;
    logic [31:0] pwdata = '0, prdata, pid_reference;
    logic pready, pslverr, reverse_run, direction_locked;
    logic [13:0][31:0] func_value;
    logic [13:0] func_valid;
    integer errors = 0, n_checks = 0, seed = 32'h2E34E77C, cyc = 0, i;
    aic_note_t q[$];
    aic_note_t nt;
    aic_row_t rows[7] = '{'{0, 16'hFF9C, 16'h03E8, 0, 5394}, '{1, 16'h03E8, 16'h03E8, 0, 6000},
        '{3, 16'hFF9C, 16'h03E8, 0, 5394}, '{4, 16'h0064, 16'hFC18, 1, -5394},
        '{4, 16'h0064, 16'hFC18, 0, 0}, '{0, 0, 16'hEC78, 1, 0}, '{0, 0, 16'h1388, 0, 29970}};

    aic_top #(.TICK_CYCLES(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .analog_input_one(ain1), .analog_input_two(ain2), .func_value(func_value),
        .func_valid(func_valid), .pid_reference(pid_reference), .reverse_run(reverse_run),
        .direction_locked(direction_locked));

    initial forever #20 pclk = ~pclk;
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic results();
        $display("Checks %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    task automatic cmp_bus(input logic [32:0] e, input logic [32:0] s);
        n_checks++;
        if (s !== e)
        begin
            errors++;
            $display("MISMATCH bus read exp %h got %h", e, s);
        end
    endtask : cmp_bus

    task automatic cmp_cmd(input logic [4:0] k, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            errors++;
            $display("MISMATCH command %0d exp %h got %h", k, e, s);
        end
    endtask : cmp_cmd

    // Holds the request until pready is seen high; upper data bits are random filler
    task automatic bus(input logic wr, input logic [13:0] ix, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= {ix, 2'b00};
        pwdata <= {16'($random(seed)), d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask : bus

    task automatic wr(input logic [13:0] ix, input logic [15:0] d);
        bus(1, ix, d);
    endtask : wr

    task automatic rd(input logic [13:0] ix, input logic [32:0] e);
        q.push_back('{16, e});
        bus(0, ix, 16'h0000);
    endtask : rd

    // Gives the registered outputs time to follow the last write before looking
    task automatic chk(input logic [4:0] k, input logic [31:0] v);
        repeat (3) @(posedge pclk);
        q.push_back('{k, {1'b0, v}});
        look <= 1;
        @(posedge pclk);
        look <= 0;
    endtask : chk

    function automatic logic [32:0] rst_exp(input int i);
        logic [18:0] map;
        map = 19'h59D1F;
        if (!map[i]) return {1'b1, 32'h0};
        if (i == 0) return {17'h0, aic_pkg::RST_FSEL1};
        if (i == 11 || i == 12) return {17'h0, aic_pkg::RST_GAIN};
        if (i == 15 || i == 16) return {17'h0, aic_pkg::RST_FTIME};
        return 33'h0;
    endfunction : rst_exp
    // ************************************************************
    // Output watcher and timeout
    // ************************************************************
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors = errors + 1;
            results();
        end
        if (psel && penable && pready && !pwrite)
        begin
            nt = q.pop_front();
            cmp_bus(nt.v, {pslverr, prdata});
        end
        else if (look)
        begin
            nt = q.pop_front();
            cmp_cmd(nt.k, nt.v[31:0], nt.k < 14 ? func_value[nt.k[3:0]] :
                nt.k == 14 ? pid_reference :
                nt.k == 15 ? {30'h0, reverse_run, direction_locked} : {18'h0, func_valid});
        end
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 19; i++) rd(aic_pkg::IDX_FSEL1 + 14'(i), rst_exp(i));
        $display("test done: register map");
        ain1 <= 16'hFFFF;
        wr(aic_pkg::IDX_FTIME1, 16'h0000);
        wr(aic_pkg::IDX_FTIME2, 16'h0000);
        wr(aic_pkg::IDX_BIAS2, 16'h0064);
        wr(aic_pkg::IDX_MAX_TORQUE, 16'h07D0);
        wr(aic_pkg::IDX_RATED_TORQUE, 16'h01F4);
        repeat (2000) @(posedge pclk);
        for (i = 1; i < 14; i++)
        begin
            wr(aic_pkg::IDX_FSEL1, 16'(i));
            chk(5'(i), (i == 1 || i == 12) ? F : i == 2 ? XPM * 2 : i == 3 ? XPM / 2 : XPM);
            chk(17, 32'(1) << i);
        end
        $display("test done: function codes");
        wr(aic_pkg::IDX_FSEL1, 16'h0001);
        wr(aic_pkg::IDX_FSEL2, 16'h0001);
        chk(1, F);
        wr(aic_pkg::IDX_SUM_EN, 16'h0001);
        chk(1, (XPM + 100) * 6);
        wr(aic_pkg::IDX_SUM_EN, 16'h0000);
        wr(aic_pkg::IDX_FSEL1, 16'h0004);
        chk(14, XPM);
        wr(aic_pkg::IDX_FSEL1, 16'h0001);
        wr(aic_pkg::IDX_FSEL2, 16'h0000);
        $display("test done: priority and sum");
        foreach (rows[n])
        begin
            wr(aic_pkg::IDX_BMODE1, rows[n].m);
            wr(aic_pkg::IDX_BIAS1, rows[n].b);
            wr(aic_pkg::IDX_GAIN1, rows[n].g);
            wr(aic_pkg::IDX_REV_EN, rows[n].r);
            chk(1, rows[n].e);
            chk(15, {30'h0, rows[n].e[31], rows[n].r[0]});
        end
        $display("test done: bias, gain and reverse");
        wr(aic_pkg::IDX_REV_EN, 16'h0001);
        wr(aic_pkg::IDX_ALT_SEL, 16'h0001);
        chk(1, F);
        chk(15, 32'h0);
        wr(aic_pkg::IDX_ALT_SEL, 16'h0000);
        wr(aic_pkg::IDX_SRC_CTRL, 16'h0000);
        chk(1, F);
        $display("test done: scaling gates");
        results();
    end
endmodule : analog_input_conditioning_bench
`default_nettype wire
